// *** core/rba_pkg.sv ***
package rba_pkg;

    // Strap thresholds sit midway between adjacent nominal levels, in millivolts
    localparam logic [15:0] UNIT_INVALID_MV = 16'h0c4e;
    localparam logic [15:0] UNIT_THR_MV [9] = '{16'h0b13, 16'h09c9, 16'h087f, 16'h0735,
                                                16'h05eb, 16'h04a1, 16'h0357, 16'h020d,
                                                16'h00b4};
    localparam logic [15:0] RACK_THR_MV [7] = '{16'h0bea, 16'h09f6, 16'h0802, 16'h0640,
                                                16'h04b0, 16'h02ee, 16'h00fa};
    localparam logic [15:0] SHELF_BASE_MV   = 16'h04e2;
    localparam logic [15:0] SHELF_STEP_MV   = 16'h09c4;

    localparam logic [15:0] VPROG_LO_MV     = 16'h0064;
    localparam logic [15:0] VPROG_HI_MV     = 16'h0bb8;
    localparam logic [15:0] VPROG_DEF_MV    = 16'h0c80;
    localparam logic [15:0] VOUT_MIN_MV     = 16'h4650;
    localparam logic [15:0] VOUT_DEF_MV     = 16'hcb20;
    localparam logic [15:0] VOUT_TOP_MV     = 16'hcf08;

    localparam logic [2:0]  ADDR_PREFIX       = 3'h4;
    localparam logic [6:0]  GENERAL_CALL_ADDR = 7'h00;
    localparam logic [6:0]  ARA_ADDR          = 7'h0c;

    // Synchronised pin vector: rs485, interlock_n, on_off_n, sda, scl
    localparam int          PIN_SCL       = 0;
    localparam int          PIN_SDA       = 1;
    localparam int          PIN_ON_OFF_N  = 2;
    localparam int          PIN_INTLK_N   = 3;
    localparam int          PIN_RS485     = 4;
    localparam logic [4:0]  PIN_RESET     = 5'h0f;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_WRX, ST_WACK, ST_TX, ST_TACK
    } rba_bus_state_type;

    // Unit and slot straps share one level table; 0 means invalid
    function automatic logic [3:0] rba_unit_code(input logic [15:0] mv);
        logic [3:0] code;
        code = 4'ha;
        for (int i = 8; i >= 0; i--) begin
            if (mv >= UNIT_THR_MV[i]) code = 4'(i + 1);
        end
        if (mv >= UNIT_INVALID_MV) code = 4'h0;
        return code;
    endfunction

    function automatic logic [3:0] rba_rack_code(input logic [15:0] mv);
        logic [3:0] code;
        code = 4'h8;
        for (int i = 6; i >= 0; i--) begin
            if (mv >= RACK_THR_MV[i]) code = 4'(i + 1);
        end
        return code;
    endfunction

    function automatic logic [3:0] rba_shelf_code(input logic [15:0] mv);
        logic [3:0] code;
        code = 4'h0;
        for (int i = 0; i < 10; i++) begin
            if (32'(mv) >= 32'(SHELF_BASE_MV) + i * 32'(SHELF_STEP_MV)) code = 4'(i + 1);
        end
        return code;
    endfunction

    // Returns {valid, four address bits}
    function automatic logic [4:0] rba_addr_map(input logic [3:0] unit, input logic [3:0] rack);
        int u;
        int r;
        int a;
        logic v;
        u = int'(unit);
        r = int'(rack);
        a = 0;
        v = 1'b1;
        if (u >= 1 && u <= 4 && r >= 1 && r <= 4) a = (r - 1) * 4 + u - 1;
        else if (u >= 1 && u <= 5 && r >= 6 && r <= 8) a = (r - 6) * 5 + u - 1;
        else if (u >= 6 && u <= 7 && r >= 1 && r <= 8) a = (r - 1) * 2 + u - 6;
        else if (u >= 8 && u <= 10 && r >= 4 && r <= 8) a = (r - 4) * 3 + u - 8;
        else v = 1'b0;
        return {v, 4'(a)};
    endfunction

    function automatic logic [15:0] rba_vprog_map(input logic [15:0] mv, input logic [15:0] top);
        int span;
        span = (int'(mv) - int'(VPROG_LO_MV)) * (int'(top) - int'(VOUT_MIN_MV))
             / (int'(VPROG_HI_MV) - int'(VPROG_LO_MV));
        if (mv >= VPROG_DEF_MV) return VOUT_DEF_MV;
        if (mv < VPROG_LO_MV) return VOUT_MIN_MV;
        if (mv > VPROG_HI_MV) return top;
        return 16'(int'(VOUT_MIN_MV) + span);
    endfunction

endpackage

// *** core/rba_sync.sv ***
`timescale 1ns/100ps
module rba_sync #(
    parameter int               WIDTH       = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_sync
);
    if (WIDTH < 1) begin : g_chk
        $error("WIDTH must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } rba_sync_state_type;

    rba_sync_state_type st;
    rba_sync_state_type next_st;

    always_comb begin
        next_st.stage1 = pin_raw;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= {RESET_VALUE, RESET_VALUE};
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync = st.stage2;
endmodule // rba_sync

// *** core/rba_bus_address.sv ***
`timescale 1ns/100ps
module rba_bus_address
    import rba_pkg::*;
#(
    parameter logic [15:0] VOUT_TOP = VOUT_TOP_MV
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        scl_pin,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    output logic             alert_out,
    output logic             alert_oe_n,
    input  wire logic        on_off_n_pin,
    input  wire logic        interlock_n_pin,
    input  wire logic        rs485_mode_pin,
    input  wire logic [15:0] unit_position_strap,
    input  wire logic [15:0] rack_position_strap,
    input  wire logic [15:0] slot_position_strap,
    input  wire logic [15:0] shelf_level,
    input  wire logic        strap_sample_valid,
    input  wire logic [15:0] vprog_level,
    input  wire logic [15:0] sw_setpoint,
    input  wire logic        sw_setpoint_valid,
    input  wire logic        state_change,
    input  wire logic        clear_faults,
    input  wire logic [7:0]  ara_pec,
    input  wire logic [7:0]  rd_data,
    output logic             rd_strobe,
    output logic [7:0]       wr_data,
    output logic             wr_valid,
    output logic             wr_first,
    output logic             wr_broadcast,
    output logic             invalid_cmd,
    output logic             straps_ready,
    output logic [3:0]       decoded_address_bits,
    output logic             address_valid,
    output logic [3:0]       bay_position,
    output logic [3:0]       slot_position,
    output logic [3:0]       shelf_position,
    output logic             main_output_on,
    output logic [15:0]      setpoint,
    output logic             pin_control
);
    if (VOUT_TOP <= VOUT_MIN_MV) begin : g_chk
        $error("VOUT_TOP must exceed the minimum output setpoint");
    end

    typedef struct packed {
        rba_bus_state_type bus;
        logic [3:0]        bitcnt;
        logic [7:0]        shreg;
        logic [7:0]        txbyte;
        logic              is_read;
        logic              is_bc;
        logic              is_ara;
        logic              ara_idx;
        logic              drive;
        logic              lost;
        logic              acked;
        logic              first;
        logic              scl_q;
        logic              sda_q;
        logic              alert;
        logic              sw_mode;
        logic [15:0]       setpoint;
        logic              ready;
        logic [3:0]        unit;
        logic [3:0]        rack;
        logic [3:0]        slot;
        logic [3:0]        shelf;
        logic [4:0]        amap;
        logic              on;
        logic [7:0]        wr_data;
        logic              wr_valid;
        logic              wr_first;
        logic              wr_bc;
        logic              rd_strobe;
        logic              invalid;
    } rba_state_type;

    rba_state_type st;
    rba_state_type next_st;
    logic [4:0]    pins;
    logic          scl_s;
    logic          sda_s;
    logic          rs485_s;
    logic          addr_ok;
    logic [6:0]    own7;

    rba_sync #(
        .WIDTH       (5),
        .RESET_VALUE (PIN_RESET)
    ) u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .pin_raw  ({rs485_mode_pin, interlock_n_pin, on_off_n_pin, sda_in, scl_pin}),
        .pin_sync (pins)
    );

    assign scl_s   = pins[PIN_SCL];
    assign sda_s   = pins[PIN_SDA];
    assign rs485_s = pins[PIN_RS485];
    assign own7    = {ADDR_PREFIX, st.amap[3:0]};
    assign addr_ok = st.ready & st.amap[4] & ~rs485_s;

    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic set_evt;
        logic clr_evt;
        rise    = scl_s & ~st.scl_q;
        fall    = ~scl_s & st.scl_q;
        start   = scl_s & st.scl_q & st.sda_q & ~sda_s;
        stop    = scl_s & st.scl_q & ~st.sda_q & sda_s;
        set_evt = state_change;
        clr_evt = clear_faults;
        next_st           = st;
        next_st.scl_q     = scl_s;
        next_st.sda_q     = sda_s;
        next_st.wr_valid  = 1'b0;
        next_st.rd_strobe = 1'b0;
        next_st.invalid   = 1'b0;

        // Straps are caught once, after power-up, before any address use
        if (strap_sample_valid && !st.ready) begin
            next_st.ready = 1'b1;
            next_st.unit  = rba_unit_code(unit_position_strap);
            next_st.rack  = rba_rack_code(rack_position_strap);
            next_st.slot  = rba_unit_code(slot_position_strap);
            next_st.shelf = rba_shelf_code(shelf_level);
            next_st.amap  = rba_addr_map(rba_unit_code(unit_position_strap),
                                         rba_rack_code(rack_position_strap));
        end

        if (start) begin
            next_st.bus    = ST_ADDR;
            next_st.bitcnt = 4'h0;
            next_st.drive  = 1'b0;
        end else if (stop) begin
            next_st.bus   = ST_IDLE;
            next_st.drive = 1'b0;
        end else begin
            case (st.bus)
                ST_ADDR, ST_WRX: begin
                    if (rise) begin
                        next_st.shreg  = {st.shreg[6:0], sda_s};
                        next_st.bitcnt = st.bitcnt + 4'h1;
                    end else if (fall && st.bitcnt == 4'h8 && st.bus == ST_ADDR) begin
                        next_st.is_read = st.shreg[0];
                        next_st.is_bc   = 1'b0;
                        next_st.is_ara  = 1'b0;
                        next_st.ara_idx = 1'b0;
                        next_st.first   = 1'b1;
                        next_st.bus     = ST_AACK;
                        next_st.drive   = 1'b1;
                        if (st.shreg[7:1] == GENERAL_CALL_ADDR && !rs485_s) begin
                            if (st.shreg[0]) begin
                                // No acknowledge and no data on a broadcast read
                                next_st.bus     = ST_IDLE;
                                next_st.drive   = 1'b0;
                                next_st.invalid = 1'b1;
                                set_evt         = 1'b1;
                            end else begin
                                next_st.is_bc = 1'b1;
                            end
                        end else if (st.shreg[7:1] == ARA_ADDR && st.shreg[0]
                                     && st.alert && addr_ok) begin
                            next_st.is_ara = 1'b1;
                            next_st.txbyte = {own7, 1'b1};
                        end else if (st.shreg[7:1] == own7 && addr_ok) begin
                            next_st.txbyte    = rd_data;
                            next_st.rd_strobe = st.shreg[0];
                        end else begin
                            next_st.bus   = ST_IDLE;
                            next_st.drive = 1'b0;
                        end
                    end else if (fall && st.bitcnt == 4'h8) begin
                        next_st.bus      = ST_WACK;
                        next_st.drive    = 1'b1;
                        next_st.wr_data  = st.shreg;
                        next_st.wr_valid = 1'b1;
                        next_st.wr_first = st.first;
                        next_st.wr_bc    = st.is_bc;
                        next_st.first    = 1'b0;
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (fall) begin
                        next_st.bitcnt = 4'h0;
                        next_st.lost   = 1'b0;
                        if (st.is_read && st.bus == ST_AACK) begin
                            next_st.bus    = ST_TX;
                            next_st.drive  = ~st.txbyte[7];
                            next_st.txbyte = {st.txbyte[6:0], 1'b0};
                        end else begin
                            next_st.bus   = ST_WRX;
                            next_st.drive = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (rise) begin
                        next_st.shreg  = {st.shreg[6:0], sda_s};
                        next_st.bitcnt = st.bitcnt + 4'h1;
                        // Sent a one but the line is low: a lower address wins
                        if (!st.drive && !sda_s) next_st.lost = 1'b1;
                    end else if (fall && st.bitcnt == 4'h8) begin
                        next_st.bus   = ST_TACK;
                        next_st.drive = 1'b0;
                        // Release only on the byte actually seen on the wire
                        if (st.is_ara && !st.ara_idx && st.shreg[7:1] == own7) begin
                            clr_evt = 1'b1;
                        end
                    end else if (fall) begin
                        next_st.drive  = ~st.lost & ~st.txbyte[7];
                        next_st.txbyte = {st.txbyte[6:0], 1'b0};
                    end
                end
                ST_TACK: begin
                    if (rise) begin
                        next_st.acked = ~sda_s;
                    end else if (fall) begin
                        next_st.bitcnt = 4'h0;
                        if (st.acked && !st.lost && !(st.is_ara && st.ara_idx)) begin
                            next_st.bus     = ST_TX;
                            next_st.ara_idx = 1'b1;
                            next_st.drive   = st.is_ara ? ~ara_pec[7] : ~rd_data[7];
                            next_st.txbyte  = st.is_ara ? {ara_pec[6:0], 1'b0}
                                                        : {rd_data[6:0], 1'b0};
                            next_st.rd_strobe = ~st.is_ara;
                        end else begin
                            next_st.bus = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_st.drive = 1'b0;
                end
            endcase
        end

        // Output enable and interlock; multidrop mode skips the enable pin
        next_st.on = st.ready & (st.slot != 4'h0) & ~pins[PIN_INTLK_N]
                   & (rs485_s | ~pins[PIN_ON_OFF_N]);
        if (next_st.on != st.on) set_evt = 1'b1;

        // A new event in the clearing cycle keeps the line asserted
        if (set_evt) next_st.alert = 1'b1;
        else if (clr_evt) next_st.alert = 1'b0;

        if (sw_setpoint_valid) begin
            next_st.sw_mode  = 1'b1;
            next_st.setpoint = sw_setpoint;
        end else if (!st.sw_mode) begin
            next_st.setpoint = rba_vprog_map(vprog_level, VOUT_TOP);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st          <= '0;
            st.bus      <= ST_IDLE;
            st.scl_q    <= 1'b1;
            st.sda_q    <= 1'b1;
            st.alert    <= 1'b1;
            st.setpoint <= VOUT_DEF_MV;
        end else begin
            st <= next_st;
        end
    end

    // Open-drain pins only ever pull low
    assign sda_out              = 1'b0;
    assign sda_oe_n             = ~st.drive;
    assign alert_out            = 1'b0;
    assign alert_oe_n           = ~st.alert;
    assign rd_strobe            = st.rd_strobe;
    assign wr_data              = st.wr_data;
    assign wr_valid             = st.wr_valid;
    assign wr_first             = st.wr_first;
    assign wr_broadcast         = st.wr_bc;
    assign invalid_cmd          = st.invalid;
    assign straps_ready         = st.ready;
    assign decoded_address_bits = st.amap[3:0];
    assign address_valid        = st.ready & st.amap[4];
    assign bay_position         = st.unit;
    assign slot_position        = st.slot;
    assign shelf_position       = st.shelf;
    assign main_output_on       = st.on;
    assign setpoint             = st.setpoint;
    assign pin_control          = ~st.sw_mode;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_unit_decode;
        $rose(st.ready) |-> st.unit == rba_unit_code($past(unit_position_strap));
    endproperty
    a_unit_decode: assert property (p_unit_decode) else $error("unit strap misdecoded");

    property p_addr_map;
        $rose(st.ready) |-> st.amap == rba_addr_map(st.unit, st.rack);
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("address map mismatch");

    property p_slot_gate;
        st.slot == 4'h0 |=> !main_output_on;
    endproperty
    a_slot_gate: assert property (p_slot_gate) else $error("output on without slot strap");

    property p_enable_pin;
        pins[PIN_ON_OFF_N] && !rs485_s |=> !main_output_on;
    endproperty
    a_enable_pin: assert property (p_enable_pin) else $error("output on with enable high");

    property p_rs485_ignore;
        rs485_s && st.ready && st.slot != 4'h0 && !pins[PIN_INTLK_N] |=> main_output_on;
    endproperty
    a_rs485_ignore: assert property (p_rs485_ignore) else $error("multidrop output off");

    property p_bc_read;
        st.invalid |-> st.bus == ST_IDLE && sda_oe_n ##1 !alert_oe_n;
    endproperty
    a_bc_read: assert property (p_bc_read) else $error("broadcast read not refused");

    property p_bc_ack;
        st.bus == ST_AACK && st.is_bc |-> !sda_oe_n;
    endproperty
    a_bc_ack: assert property (p_bc_ack) else $error("broadcast write not acknowledged");

    property p_alert_release;
        $rose(alert_oe_n) |-> $past(clear_faults) || ($past(st.bus) == ST_TX && st.is_ara);
    endproperty
    a_alert_release: assert property (p_alert_release) else $error("alert released early");

    property p_arb_lost;
        st.bus == ST_TX && st.lost |-> sda_oe_n;
    endproperty
    a_arb_lost: assert property (p_arb_lost) else $error("drives after losing arbitration");

    property p_alert_set;
        state_change |=> !alert_oe_n;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("state change without alert");

    property p_vprog_low;
        !st.sw_mode && !sw_setpoint_valid && vprog_level < VPROG_LO_MV
            |=> setpoint == VOUT_MIN_MV;
    endproperty
    a_vprog_low: assert property (p_vprog_low) else $error("low pin level not at minimum");

    property p_sw_hold;
        st.sw_mode && !sw_setpoint_valid |=> $stable(setpoint) && !pin_control;
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("pin moved setpoint after takeover");

    c_bc_write: cover property (wr_valid && wr_broadcast);
    c_ara_release: cover property ($rose(alert_oe_n) && st.is_ara);
    c_bc_read: cover property (invalid_cmd);
    c_sw_take: cover property ($fell(pin_control));
endmodule // rba_bus_address

// *** tb/rba_host.sv ***
`timescale 1ns/100ps
module rba_host (
    output logic     scl,
    output logic     sda_rel,
    input wire logic sda
);
    initial {scl, sda_rel} = 2'h3;
    // Data moves only while the clock is low, so no false start or stop
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        #24 scl = 1'b1;
        #12 s = sda;
        #12 scl = 1'b0;
    endtask
    task automatic start;
        #24 sda_rel = 1'b0;
        #24 scl = 1'b0;
    endtask
    task automatic stop;
        sda_rel = 1'b0;
        #24 scl = 1'b1;
        #24 sda_rel = 1'b1;
        #24;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ao, output logic [7:0] rx,
                        output logic ai);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ao, ai);
    endtask
endmodule // rba_host

// *** tb/rba_bus_address_tb.sv ***
`timescale 1ns/100ps
module rba_bus_address_tb;
    import rba_pkg::*;
    logic        sys_clk, resetn, scl_pin, sda_rel, on_off_n_pin, interlock_n_pin;
    logic        rs485_mode_pin, strap_sample_valid, sw_setpoint_valid, state_change, clear_faults;
    logic [15:0] unit_position_strap, rack_position_strap, slot_position_strap, shelf_level;
    logic [15:0] vprog_level, sw_setpoint, setpoint;
    logic [7:0]  ara_pec, rd_data, wr_data, rx;
    logic        sda_out, sda_oe_n, alert_out, alert_oe_n, rd_strobe, wr_valid, wr_first;
    logic        wr_broadcast, invalid_cmd, straps_ready, address_valid, main_output_on;
    logic        pin_control;
    logic [3:0]  decoded_address_bits, bay_position, slot_position, shelf_position;
    wire         sda_in = sda_rel & sda_oe_n;
    wire         alert = alert_oe_n;
    int          miscompares, checks, inv, rds, a, u, r, v;
    logic [8:0]  wq[$];
    int          umv[11] = '{0, 3000, 2670, 2340, 2010, 1680, 1350, 1020, 690, 360, 0};
    int          rmv[9] = '{0, 3300, 2800, 2300, 1800, 1400, 1000, 500, 0};
    rba_bus_address dut (.*);
    rba_host host (.scl(scl_pin), .sda_rel(sda_rel), .sda(sda_in));
    function automatic int exp_addr(int u, int r);
        if (u <= 4 && r <= 4) return (r - 1) * 4 + u - 1;
        if (u <= 5 && r >= 6) return (r - 6) * 5 + u - 1;
        if (u inside {6, 7}) return (r - 1) * 2 + u - 6;
        if (u >= 8 && r >= 4) return (r - 4) * 3 + u - 8;
        return -1;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic ao, input logic ae);
        logic ai;
        host.xfer(b, ao, rx, ai);
        chk("ack", 16'(ae), 16'(ai));
    endtask
    task automatic wr(input logic [7:0] ad, input logic ae);
        logic [7:0] d;
        d = 8'($urandom);
        host.start;
        tx(ad, 1'b1, ae);
        if (!ae) wq.push_back({ad == 8'h00, d});
        if (!ae) tx(d, 1'b1, 1'b0);
        host.stop;
    endtask
    task automatic rd;
        host.start;
        tx({3'h4, 4'(a), 1'b1}, 1'b1, 1'b0);
        tx(8'hff, 1'b1, 1'b1);
        chk("rd_data", 16'(rd_data), 16'(rx));
        host.stop;
    endtask
    task automatic ara;
        host.start;
        tx(8'h19, 1'b1, 1'b0);
        tx(8'hff, 1'b0, 1'b0);
        chk("ara_addr", {9'h0, 3'h4, 4'(a)}, 16'(rx[7:1]));
        tx(8'hff, 1'b1, 1'b1);
        chk("pec", 16'(ara_pec), 16'(rx));
        host.stop;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic boot(input int s);
        resetn <= 1'b0;
        unit_position_strap <= 16'(umv[u]);
        rack_position_strap <= 16'(rmv[r]);
        slot_position_strap <= 16'(s);
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        strap_sample_valid <= 1'b1;
        @(posedge sys_clk);
        strap_sample_valid <= 1'b0;
        repeat (8) @(posedge sys_clk);
        a = exp_addr(u, r);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (invalid_cmd === 1'b1) inv++;
        if (rd_strobe === 1'b1) rds++;
        if (wr_valid === 1'b1) begin
            chk("wr_data", wq.size() ? 16'(wq.pop_front()) : 'x,
                16'({wr_broadcast, wr_data}));
            chk("wr_first", 16'h1, 16'(wr_first));
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict;
    end
    initial begin
        {resetn, strap_sample_valid, sw_setpoint_valid, state_change, clear_faults} = '0;
        {on_off_n_pin, interlock_n_pin, rs485_mode_pin, rd_data, ara_pec} = {3'h0, 8'h0, 8'h5a};
        {shelf_level, vprog_level, sw_setpoint} = {16'h1d4c, 16'h0, 16'h9c40};
        void'($urandom(68));
        for (int i = 0; i < 8; i++) begin
            u = (i == 7) ? 7 : 1 + $urandom % 10;
            r = (i == 7) ? 8 : 1 + $urandom % 8;
            boot(i % 2 ? 690 : 3300);
            chk("ready", 16'h1, 16'(straps_ready));
            chk("valid", 16'(a >= 0), 16'(address_valid));
            if (a >= 0) chk("bits", 16'(a), 16'(decoded_address_bits));
            chk("bay", 16'(u), 16'(bay_position));
            chk("slot", i % 2 ? 16'h8 : 16'h0, 16'(slot_position));
            chk("shelf", 16'h3, 16'(shelf_position));
            chk("out", 16'(i % 2 == 1), 16'(main_output_on));
            wr({3'h4, 4'(a < 0 ? 0 : a), 1'b0}, a < 0);
        end
        ara;
        chk("alert", 16'h1, 16'(alert));
        wr(8'h00, 1'b0);
        rd_data <= 8'($urandom);
        @(posedge sys_clk);
        rd;
        chk("rd_strobe", 16'h1, 16'(rds));
        wr(8'h01, 1'b1);
        chk("invalid", 16'h1, 16'(inv));
        chk("alert", 16'h0, 16'(alert));
        ara;
        chk("alert", 16'h1, 16'(alert));
        for (int j = 0; j < 8; j++) begin
            {rs485_mode_pin, interlock_n_pin, on_off_n_pin} <= 3'(j);
            repeat (8) @(posedge sys_clk);
            chk("out", 16'(j[1] == 0 && (j[2] || !j[0])), 16'(main_output_on));
        end
        for (int j = 0; j < 3; j++) begin
            v = j == 0 ? 50 : j == 1 ? 3300 : 100 + $urandom % 2901;
            vprog_level <= 16'(v);
            repeat (3) @(posedge sys_clk);
            chk("setpoint", j == 0 ? VOUT_MIN_MV : j == 1 ? VOUT_DEF_MV :
                16'(18000 + (v - 100) * 35000 / 2900), setpoint);
        end
        sw_setpoint_valid <= 1'b1;
        @(posedge sys_clk);
        {sw_setpoint_valid, vprog_level} <= {1'b0, 16'h0};
        repeat (3) @(posedge sys_clk);
        chk("setpoint", 16'h9c40, setpoint);
        chk("pin_control", 16'h0, 16'(pin_control));
        print_verdict;
    end
endmodule // rba_bus_address_tb
